// ### design/rc_pkg.sv
// Overview of operation
// - watchdog timeout reset drives the watchdog flag to 0
// - master-clear pin reset drives the pin flag to 0
// - reset instruction drives the reset-instruction flag to 0
// - firmware writes 1 to re-arm watchdog, pin, instruction and memory flags
// - power-on reset clears the power-on flag; firmware sets it afterwards
// - brown-out or power-on reset clears the brown-out flag; firmware sets it
// - memory violation reset drives the memory-violation flag to 0
// - power-on and brown-out set memory-violation flag; other resets keep it
// - aux register bits 7..2 and 0 read as 0 and ignore writes
// - watchdog clear outside the window drives the window flag to 0
// - return stack overflow sets the overflow flag until firmware clears it
// - return stack underflow sets the underflow flag until firmware clears it
package rc_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_MAIN = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_AUX = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h3;
  localparam int unsigned BIT_STACK_OVERFLOW_FLAG = 7;
  localparam int unsigned BIT_STACK_UNDERFLOW_FLAG = 6;
  localparam int unsigned BIT_WINDOW = 5;
  localparam int unsigned BIT_WDOG = 4;
  localparam int unsigned BIT_PIN = 3;
  localparam int unsigned BIT_INSTR = 2;
  localparam int unsigned BIT_POR = 1;
  localparam int unsigned BIT_BOR = 0;
  localparam int unsigned BIT_MEMORY_VIOLATION_FLAG = 1;
  localparam logic [DATA_W-1:0] MAIN_POR_VALUE = 8'h3C;
  localparam logic [DATA_W-1:0] AUX_POR_VALUE = 8'h02;
  localparam logic [DATA_W-1:0] AUX_IMPL_MASK = 8'h02;
  localparam logic [DATA_W-1:0] IRQ_MASK_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
endpackage

// ### design/reg_access_if.sv
interface reg_access_if;
  logic wr_main;
  logic wr_aux;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic rd_main;
  logic rd_aux;
  logic rd_irq_status;
  logic rd_irq_mask;
  logic [rc_pkg::DATA_W-1:0] wdata;
  modport decoder (
    output wr_main, wr_aux, wr_irq_status, wr_irq_mask,
    output rd_main, rd_aux, rd_irq_status, rd_irq_mask, wdata
  );
  modport regs (
    input wr_main, wr_aux, wr_irq_status, wr_irq_mask,
    input rd_main, rd_aux, rd_irq_status, rd_irq_mask, wdata
  );
endinterface

// ### design/reg_port_decode.sv
module reg_port_decode (
  input wire logic [rc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [rc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  reg_access_if.decoder port
);
  wire logic hit_main;
  wire logic hit_aux;
  wire logic hit_status;
  wire logic hit_mask;
  assign hit_main = (reg_addr == rc_pkg::OFS_MAIN);
  assign hit_aux = (reg_addr == rc_pkg::OFS_AUX);
  assign hit_status = (reg_addr == rc_pkg::OFS_IRQ_STATUS);
  assign hit_mask = (reg_addr == rc_pkg::OFS_IRQ_MASK);
  // unmapped addresses decode to nothing: writes drop, reads return zero
  assign port.wr_main = reg_wr & hit_main;
  assign port.wr_aux = reg_wr & hit_aux;
  assign port.wr_irq_status = reg_wr & hit_status;
  assign port.wr_irq_mask = reg_wr & hit_mask;
  assign port.rd_main = reg_rd & hit_main;
  assign port.rd_aux = reg_rd & hit_aux;
  assign port.rd_irq_status = reg_rd & hit_status;
  assign port.rd_irq_mask = reg_rd & hit_mask;
  assign port.wdata = reg_wdata;
endmodule // reg_port_decode

// ### design/irq_sticky.sv
module irq_sticky #(
  parameter int unsigned N = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [N-1:0] evt,
  reg_access_if.regs port,
  output logic [N-1:0] status,
  output logic [N-1:0] mask,
  output logic irq
);
  if (N < 1 || N > rc_pkg::DATA_W) begin : g_check
    $error("irq_sticky: N must lie in 1..DATA_W");
  end
  logic [N-1:0] status_r;
  logic [N-1:0] mask_r;
  for (genvar i = 0; i < N; i++) begin : g_bit
    wire logic clr;
    assign clr = port.wr_irq_status & port.wdata[i];
    // an event in the clearing cycle wins so it is never lost
    always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
        status_r[i] <= 1'h0;
      end else if (evt[i]) begin
        status_r[i] <= 1'h1;
      end else if (clr) begin
        status_r[i] <= 1'h0;
      end
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mask_r <= rc_pkg::IRQ_MASK_RESET[N-1:0];
    end else if (port.wr_irq_mask) begin
      mask_r <= port.wdata[N-1:0];
    end
  end
  assign status = status_r;
  assign mask = mask_r;
  assign irq = |(status_r & mask_r);
endmodule // irq_sticky

// ### design/reset_cause_flags.sv
// Local design decisions: the register addresses and the address-and-strobe port.
module reset_cause_flags (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [rc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [rc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [rc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic watchdog_timeout_evt,
  input wire logic window_violation_evt,
  input wire logic pin_reset_evt,
  input wire logic reset_instr_evt,
  input wire logic brownout_evt,
  input wire logic memory_violation_evt,
  input wire logic stack_overflow_evt,
  input wire logic stack_underflow_evt,
  output logic [rc_pkg::DATA_W-1:0] cause_main,
  output logic [rc_pkg::DATA_W-1:0] cause_aux,
  output logic irq
);
  // flag storage for the cause of the latest reset; rst_b is the power-on
  // reset, every other reset kind arrives as a one-cycle event pulse
  reg_access_if bus_if ();

  // the interrupt map lends the power-on position to the memory flag, so
  // those two bit positions must stay equal
  if (rc_pkg::BIT_MEMORY_VIOLATION_FLAG != rc_pkg::BIT_POR) begin : g_check
    $error("reset_cause_flags: memory flag bit must match the power-on bit");
  end

  reg_port_decode u_decode (
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .port(bus_if.decoder)
  );

  logic [rc_pkg::DATA_W-1:0] main_r;
  logic [rc_pkg::DATA_W-1:0] main_nxt;
  logic [rc_pkg::DATA_W-1:0] aux_r;
  logic [rc_pkg::DATA_W-1:0] aux_nxt;
  logic [rc_pkg::DATA_W-1:0] rdata_r;
  logic [rc_pkg::DATA_W-1:0] rdata_nxt;
  wire logic [rc_pkg::DATA_W-1:0] main_hw_clear;
  wire logic [rc_pkg::DATA_W-1:0] main_hw_set;
  wire logic [rc_pkg::DATA_W-1:0] aux_hw_clear;
  wire logic [rc_pkg::DATA_W-1:0] aux_hw_set;
  wire logic [rc_pkg::DATA_W-1:0] main_sw;
  wire logic [rc_pkg::DATA_W-1:0] aux_sw;
  wire logic [rc_pkg::DATA_W-1:0] irq_evt;
  wire logic [rc_pkg::DATA_W-1:0] irq_status;
  wire logic [rc_pkg::DATA_W-1:0] irq_mask;
  wire logic [rc_pkg::DATA_W-1:0] rd_sel;

  // reset causes that hardware drives to 0
  assign main_hw_clear[rc_pkg::BIT_STACK_OVERFLOW_FLAG] = 1'h0;
  assign main_hw_clear[rc_pkg::BIT_STACK_UNDERFLOW_FLAG] = 1'h0;
  assign main_hw_clear[rc_pkg::BIT_WINDOW] = window_violation_evt;
  assign main_hw_clear[rc_pkg::BIT_WDOG] = watchdog_timeout_evt;
  assign main_hw_clear[rc_pkg::BIT_PIN] = pin_reset_evt;
  assign main_hw_clear[rc_pkg::BIT_INSTR] = reset_instr_evt;
  // the power-on flag is cleared only by rst_b itself
  assign main_hw_clear[rc_pkg::BIT_POR] = 1'h0;
  assign main_hw_clear[rc_pkg::BIT_BOR] = brownout_evt;

  // stack faults are the only causes that hardware drives to 1 in the main register
  assign main_hw_set[rc_pkg::BIT_STACK_OVERFLOW_FLAG] = stack_overflow_evt;
  assign main_hw_set[rc_pkg::BIT_STACK_UNDERFLOW_FLAG] = stack_underflow_evt;
  assign main_hw_set[rc_pkg::BIT_WINDOW:rc_pkg::BIT_BOR] = 6'h00;

  assign aux_hw_clear = memory_violation_evt ? rc_pkg::AUX_IMPL_MASK : rc_pkg::ZERO_BYTE;
  assign aux_hw_set = brownout_evt ? rc_pkg::AUX_IMPL_MASK : rc_pkg::ZERO_BYTE;

  // firmware value first, then hardware overrides so no event is lost
  assign main_sw = bus_if.wr_main ? bus_if.wdata : main_r;
  assign aux_sw = bus_if.wr_aux ? bus_if.wdata : aux_r;

  // untouched bits hold, so a flag outlives resets of other kinds
  assign main_nxt = (main_sw & ~main_hw_clear) | main_hw_set;
  // a memory violation in the same cycle as a brown-out still reads as 0
  assign aux_nxt = ((aux_sw | aux_hw_set) & ~aux_hw_clear) & rc_pkg::AUX_IMPL_MASK;

  // power-on values; rst_b stands for the power-on reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      main_r <= rc_pkg::MAIN_POR_VALUE;
      aux_r <= rc_pkg::AUX_POR_VALUE;
    end else begin
      main_r <= main_nxt;
      aux_r <= aux_nxt;
    end
  end

  // interrupt bits share the main layout; memory violation sits on bit 1
  assign irq_evt = main_hw_clear | main_hw_set | aux_hw_clear;

  irq_sticky #(
    .N(rc_pkg::DATA_W)
  ) u_irq (
    .clock(clock),
    .rst_b(rst_b),
    .evt(irq_evt),
    .port(bus_if.regs),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  assign rd_sel = bus_if.rd_main ? main_r :
                  bus_if.rd_aux ? aux_r :
                  bus_if.rd_irq_status ? irq_status :
                  bus_if.rd_irq_mask ? irq_mask :
                  rc_pkg::ZERO_BYTE;
  // read data stand for one cycle only, zero otherwise
  assign rdata_nxt = reg_rd ? rd_sel : rc_pkg::ZERO_BYTE;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= rc_pkg::ZERO_BYTE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign cause_main = main_r;
  assign cause_aux = aux_r;

  wdog_clear_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    watchdog_timeout_evt |=> !main_r[rc_pkg::BIT_WDOG]
  ) else $error("watchdog flag not cleared by timeout");

  pin_clear_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    pin_reset_evt |=> !main_r[rc_pkg::BIT_PIN] && !cause_main[rc_pkg::BIT_PIN]
  ) else $error("pin flag not cleared by pin reset");

  instr_clear_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    reset_instr_evt |=> !main_r[rc_pkg::BIT_INSTR]
  ) else $error("instruction flag not cleared");

  rearm_main_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    bus_if.wr_main && bus_if.wdata[rc_pkg::BIT_WDOG] && bus_if.wdata[rc_pkg::BIT_PIN]
      && bus_if.wdata[rc_pkg::BIT_INSTR] && !watchdog_timeout_evt && !pin_reset_evt
      && !reset_instr_evt
    |=> main_r[rc_pkg::BIT_WDOG] && main_r[rc_pkg::BIT_PIN] && main_r[rc_pkg::BIT_INSTR]
  ) else $error("firmware re-arm of main flags lost");

  rearm_memory_violation_flag_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    bus_if.wr_aux && bus_if.wdata[rc_pkg::BIT_MEMORY_VIOLATION_FLAG] && !memory_violation_evt
    |=> aux_r[rc_pkg::BIT_MEMORY_VIOLATION_FLAG]
  ) else $error("firmware re-arm of memory flag lost");

  por_hold_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    !bus_if.wr_main |=> main_r[rc_pkg::BIT_POR] == $past(main_r[rc_pkg::BIT_POR])
  ) else $error("power-on flag changed without a write");

  bor_clear_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    brownout_evt |=> !main_r[rc_pkg::BIT_BOR]
  ) else $error("brown-out flag not cleared");

  memory_violation_flag_clear_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    memory_violation_evt |=> !aux_r[rc_pkg::BIT_MEMORY_VIOLATION_FLAG]
  ) else $error("memory flag not cleared");

  memory_violation_flag_bor_set_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    brownout_evt && !memory_violation_evt |=> aux_r[rc_pkg::BIT_MEMORY_VIOLATION_FLAG]
  ) else $error("brown-out did not set memory flag");

  memory_violation_flag_keep_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    !brownout_evt && !memory_violation_evt && !bus_if.wr_aux
    |=> $stable(aux_r)
  ) else $error("memory flag changed on another reset");

  aux_unimpl_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    bus_if.rd_aux |=> (reg_rdata & ~rc_pkg::AUX_IMPL_MASK) == rc_pkg::ZERO_BYTE
  ) else $error("unimplemented aux bits read nonzero");

  window_clear_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    window_violation_evt |=> !main_r[rc_pkg::BIT_WINDOW]
  ) else $error("window flag not cleared");

  ovf_sticky_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    stack_overflow_evt ##1 (!bus_if.wr_main) [*3]
    |-> main_r[rc_pkg::BIT_STACK_OVERFLOW_FLAG]
  ) else $error("overflow flag did not stay set");

  unf_sticky_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    stack_underflow_evt |=> main_r[rc_pkg::BIT_STACK_UNDERFLOW_FLAG]
  ) else $error("underflow flag not set");

  main_keep_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    !bus_if.wr_main && main_hw_clear == rc_pkg::ZERO_BYTE
      && main_hw_set == rc_pkg::ZERO_BYTE
    |=> $stable(main_r)
  ) else $error("main flags changed with no cause");

  read_data_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    bus_if.rd_main && !bus_if.wr_main && !(|main_hw_clear) && !(|main_hw_set)
    |=> reg_rdata == main_r
  ) else $error("main read returned wrong data");

  read_idle_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == rc_pkg::ZERO_BYTE
  ) else $error("read data not zero outside answer");

  irq_level_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    watchdog_timeout_evt && irq_mask[rc_pkg::BIT_WDOG] && !bus_if.wr_irq_mask
    |=> irq
  ) else $error("unmasked event raised no interrupt");

  wdog_hold_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    !watchdog_timeout_evt && !bus_if.wr_main |=> $stable(main_r[rc_pkg::BIT_WDOG])
  ) else $error("watchdog flag moved with no cause");

  window_hold_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    !window_violation_evt && !bus_if.wr_main |=> $stable(main_r[rc_pkg::BIT_WINDOW])
  ) else $error("window flag moved with no cause");

  pin_hold_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    !pin_reset_evt && !bus_if.wr_main |=> $stable(main_r[rc_pkg::BIT_PIN])
  ) else $error("pin flag moved with no cause");

  instr_hold_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    !reset_instr_evt && !bus_if.wr_main |=> $stable(main_r[rc_pkg::BIT_INSTR])
  ) else $error("instruction flag moved with no cause");

  bor_hold_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    !brownout_evt && !bus_if.wr_main |=> $stable(main_r[rc_pkg::BIT_BOR])
  ) else $error("brown-out flag moved with no cause");

  ovf_keep_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    main_r[rc_pkg::BIT_STACK_OVERFLOW_FLAG] && !bus_if.wr_main |=> main_r[rc_pkg::BIT_STACK_OVERFLOW_FLAG]
  ) else $error("overflow flag dropped without a write");

  unf_keep_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    main_r[rc_pkg::BIT_STACK_UNDERFLOW_FLAG] && !bus_if.wr_main |=> main_r[rc_pkg::BIT_STACK_UNDERFLOW_FLAG]
  ) else $error("underflow flag dropped without a write");

  main_write_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    bus_if.wr_main && main_hw_clear == rc_pkg::ZERO_BYTE && main_hw_set == rc_pkg::ZERO_BYTE
    |=> main_r == $past(bus_if.wdata)
  ) else $error("main write did not land");

  aux_write_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    bus_if.wr_aux && !memory_violation_evt && !brownout_evt
    |=> aux_r == ($past(bus_if.wdata) & rc_pkg::AUX_IMPL_MASK)
  ) else $error("aux write touched an empty bit");

  aux_zero_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    (aux_r & ~rc_pkg::AUX_IMPL_MASK) == rc_pkg::ZERO_BYTE
  ) else $error("unimplemented aux bit set");

  memory_violation_flag_status_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    memory_violation_evt |=> irq_status[rc_pkg::BIT_MEMORY_VIOLATION_FLAG]
  ) else $error("memory event missing from status");

  aux_read_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    bus_if.rd_aux && !bus_if.wr_aux && !memory_violation_evt && !brownout_evt
    |=> reg_rdata == aux_r
  ) else $error("aux read returned wrong data");

  status_read_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    bus_if.rd_irq_status && !bus_if.wr_irq_status && irq_evt == rc_pkg::ZERO_BYTE
    |=> reg_rdata == irq_status
  ) else $error("status read returned wrong data");

  mask_read_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    bus_if.rd_irq_mask && !bus_if.wr_irq_mask |=> reg_rdata == irq_mask
  ) else $error("mask read returned wrong data");

  unmapped_read_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    reg_rd && !bus_if.rd_main && !bus_if.rd_aux && !bus_if.rd_irq_status && !bus_if.rd_irq_mask
    |=> reg_rdata == rc_pkg::ZERO_BYTE
  ) else $error("unmapped read returned data");

  status_set_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    watchdog_timeout_evt |=> irq_status[rc_pkg::BIT_WDOG]
  ) else $error("watchdog event missing from status");

  status_clear_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    bus_if.wr_irq_status && bus_if.wdata[rc_pkg::BIT_WDOG] && !watchdog_timeout_evt
    |=> !irq_status[rc_pkg::BIT_WDOG]
  ) else $error("status bit not cleared by write");

  mask_write_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    bus_if.wr_irq_mask |=> irq_mask == $past(bus_if.wdata)
  ) else $error("mask write did not land");

  irq_low_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    bus_if.wr_irq_mask && bus_if.wdata == rc_pkg::ZERO_BYTE |=> !irq
  ) else $error("interrupt high with every bit masked");

  bor_status_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    brownout_evt |=> irq_status[rc_pkg::BIT_BOR]
  ) else $error("brown-out event missing from status");

  ovf_status_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    stack_overflow_evt |=> irq_status[rc_pkg::BIT_STACK_OVERFLOW_FLAG]
  ) else $error("overflow event missing from status");
endmodule // reset_cause_flags

// ### sim/tb.sv
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
  $display("Error %0t: mismatch got %h expected %h", $time, got, exp); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock;
  logic rst_b;
  logic [rc_pkg::ADDR_W-1:0] reg_addr;
  logic [rc_pkg::DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [rc_pkg::DATA_W-1:0] reg_rdata;
  logic [7:0] evt;
  logic [rc_pkg::DATA_W-1:0] cause_main;
  logic [rc_pkg::DATA_W-1:0] cause_aux;
  logic irq;
  logic [7:0] rd_val;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycle_cnt = 0;
  // event bits: 0 watchdog, 1 window, 2 pin, 3 instr, 4 brownout, 5 memory, 6 overflow, 7 underflow
  int order [8] = '{5, 0, 1, 2, 3, 6, 7, 4};
  logic [7:0] exp_main [8] = '{8'h3F, 8'h2F, 8'h1F, 8'h37, 8'h3B, 8'hBF, 8'h7F, 8'h3E};
  logic [7:0] exp_aux [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02};

  reset_cause_flags u_dut (
    .clock(clock),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .watchdog_timeout_evt(evt[0]),
    .window_violation_evt(evt[1]),
    .pin_reset_evt(evt[2]),
    .reset_instr_evt(evt[3]),
    .brownout_evt(evt[4]),
    .memory_violation_evt(evt[5]),
    .stack_overflow_evt(evt[6]),
    .stack_underflow_evt(evt[7]),
    .cause_main(cause_main),
    .cause_aux(cause_aux),
    .irq(irq)
  );

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic finish_test();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // the run is about a hundred cycles; this only cuts a hang short
  always @(posedge clock) begin
    cycle_cnt++;
    if (cycle_cnt >= 5000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic reg_write(input logic [3:0] addr, input logic [7:0] data);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= addr;
    reg_wdata <= data;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic reg_read(input logic [3:0] addr);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= addr;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask

  task automatic pulse(input int idx);
    @(posedge clock);
    evt[idx] <= 1'b1;
    @(posedge clock);
    evt <= 8'h00;
    #1;
  endtask

  initial begin
    rst_b = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    evt = 8'h00;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    reg_read(rc_pkg::OFS_MAIN);
    `CHK(rd_val, 8'h3C)
    reg_read(rc_pkg::OFS_AUX);
    `CHK(rd_val, 8'h02)
    @(posedge clock);
    #1;
    `CHK(reg_rdata, 8'h00) // read data stands one cycle only
    reg_read(4'h7);
    `CHK(rd_val, 8'h00) // unmapped address
    reg_write(4'h7, 8'h00);
    `CHK(cause_main, 8'h3C) // unmapped write lands nowhere
    `CHK(cause_aux, 8'h02)
    // each cause on its own, from a fully re-armed register
    for (int i = 0; i < 8; i++) begin
      reg_write(rc_pkg::OFS_MAIN, 8'h3F);
      pulse(order[i]);
      `CHK(cause_main, exp_main[i])
      `CHK(cause_aux, exp_aux[i])
      reg_read(rc_pkg::OFS_MAIN);
      `CHK(rd_val, exp_main[i])
    end
    // memory flag re-armed by firmware while the empty aux bits stay 0
    pulse(5);
    `CHK(cause_aux, 8'h00)
    reg_write(rc_pkg::OFS_AUX, 8'hFF);
    reg_read(rc_pkg::OFS_AUX);
    `CHK(rd_val, 8'h02)
    // firmware clears a stack flag it no longer needs
    pulse(6);
    reg_write(rc_pkg::OFS_MAIN, 8'h3F);
    `CHK(cause_main, 8'h3F)
    // interrupt: every event seen, masked out, then cleared
    reg_read(rc_pkg::OFS_IRQ_STATUS);
    `CHK(rd_val, 8'hFF)
    `CHK(irq, 1'b0)
    reg_write(rc_pkg::OFS_IRQ_STATUS, 8'hFF);
    reg_read(rc_pkg::OFS_IRQ_STATUS);
    `CHK(rd_val, 8'h00)
    reg_write(rc_pkg::OFS_IRQ_MASK, 8'h10);
    `CHK(irq, 1'b0)
    pulse(0);
    `CHK(irq, 1'b1)
    `CHK(cause_aux, 8'h02)
    reg_read(rc_pkg::OFS_IRQ_MASK);
    `CHK(rd_val, 8'h10)
    reg_write(rc_pkg::OFS_IRQ_MASK, 8'h00);
    `CHK(irq, 1'b0)
    reg_write(rc_pkg::OFS_IRQ_MASK, 8'h10);
    `CHK(irq, 1'b1)
    reg_write(rc_pkg::OFS_IRQ_STATUS, 8'h10);
    `CHK(irq, 1'b0)
    `CHK(cause_main, 8'h2F)
    pulse(2);
    `CHK(cause_main, 8'h27)
    // a cause arriving in the cycle of a firmware re-arm still clears its flag
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= rc_pkg::OFS_MAIN;
    reg_wdata <= 8'h3F;
    evt[0] <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    evt <= 8'h00;
    #1;
    `CHK(cause_main, 8'h2F)
    `CHK(irq, 1'b1)
    // a second power-on in mid-run restores the power-on picture
    @(posedge clock);
    rst_b <= 1'b0;
    #1;
    `CHK(cause_main, 8'h3C)
    `CHK(cause_aux, 8'h02)
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    reg_read(rc_pkg::OFS_IRQ_MASK);
    `CHK(rd_val, 8'h00)
    reg_read(rc_pkg::OFS_IRQ_STATUS);
    `CHK(rd_val, 8'h00)
    `CHK(irq, 1'b0)
    finish_test();
  end
endmodule // tb
